//--- rtl/dsp_regs.svh
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define DSP_IDX_CTL_FIRST  3'h0
`define DSP_IDX_CTL_SECOND 3'h1
`define DSP_IDX_COUNT      3'h2
`define DSP_IDX_CMP_A      3'h3
`define DSP_IDX_CMP_B      3'h4
`define DSP_IDX_CAP_TOP    3'h5
`define DSP_IDX_FLAGS      3'h6
`define DSP_IDX_PIN_DIR    3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSP_ACT_A_MSB   7
`define DSP_ACT_A_LSB   6
`define DSP_ACT_B_MSB   5
`define DSP_ACT_B_LSB   4
`define DSP_MODE_LO_MSB 1
`define DSP_MODE_LO_LSB 0
`define DSP_MODE_HI_MSB 4
`define DSP_MODE_HI_LSB 3
`define DSP_CSEL_MSB    2
`define DSP_CSEL_LSB    0
`define DSP_FLAG_OVF    0
`define DSP_FLAG_CMPA   1
`define DSP_FLAG_CMPB   2
`define DSP_FLAG_CAP    5

// ----------------------------------------
// Values and codes
// ----------------------------------------
`define DSP_ZERO16      16'h0000
`define DSP_ONE16       16'h0001
`define DSP_TOP_8BIT    16'h00FF
`define DSP_TOP_9BIT    16'h01FF
`define DSP_TOP_10BIT   16'h03FF
`define DSP_COUNT_MAX   16'hFFFF
`define DSP_MODE_PC8    4'h1
`define DSP_MODE_PC9    4'h2
`define DSP_MODE_PC10   4'h3
`define DSP_MODE_PFC_CAP 4'h8
`define DSP_MODE_PFC_CMP 4'h9
`define DSP_MODE_PC_CAP 4'hA
`define DSP_MODE_PC_CMP 4'hB
`define DSP_ACT_TOGGLE  2'h1
`define DSP_ACT_NONINV  2'h2
`define DSP_ACT_INV     2'h3
`define DSP_CSEL_DIV1   3'h1
`define DSP_CSEL_DIV8   3'h2
`define DSP_CSEL_DIV64  3'h3
`define DSP_CSEL_DIV256 3'h4
`define DSP_CSEL_DIV1K  3'h5
`define DSP_TC_DIV1     10'h000
`define DSP_TC_DIV8     10'h007
`define DSP_TC_DIV64    10'h03F
`define DSP_TC_DIV256   10'h0FF
`define DSP_TC_DIV1K    10'h3FF

`endif

//--- rtl/dsp_pkg.sv
package dsp_pkg;

    // Count direction
    typedef enum logic {
        dsp_cnt_up,
        dsp_cnt_down
    } dsp_dir_type;

    // Prescaler state
    typedef struct packed {
        logic [9:0] div_cnt;
        logic       tick;
    } dsp_presc_type;

    // Compare output unit state
    typedef struct packed {
        logic level;
        logic pin_out;
        logic pin_oe;
    } dsp_cmp_type;

    // Main block state
    typedef struct packed {
        logic [7:0]  timer_control_first;
        logic [4:0]  timer_control_second;
        logic [15:0] timer_count;
        dsp_dir_type count_dir;
        logic [15:0] compare_buf_a;
        logic [15:0] compare_buf_b;
        logic [15:0] compare_value_a;
        logic [15:0] compare_value_b;
        logic [15:0] capture_top_value;
        logic [5:0]  flags;
        logic [1:0]  pin_direction_bit;
        logic [15:0] rdata;
    } dsp_top_type;

endpackage

//--- rtl/dsp_presc.sv
`timescale 1ns/1ns
`include "dsp_regs.svh"

module dsp_presc (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Divider select and tick
    input  wire logic [2:0] clk_sel,
    output logic            tick
);
    import dsp_pkg::*;

    dsp_presc_type s_reg;
    dsp_presc_type s_next;
    logic [9:0]    term;
    logic          run;

    // Terminal count for the selected divider
    always_comb begin
        run  = 1'b1;
        term = `DSP_TC_DIV1;
        case (clk_sel)
            `DSP_CSEL_DIV1:   term = `DSP_TC_DIV1;
            `DSP_CSEL_DIV8:   term = `DSP_TC_DIV8;
            `DSP_CSEL_DIV64:  term = `DSP_TC_DIV64;
            `DSP_CSEL_DIV256: term = `DSP_TC_DIV256;
            `DSP_CSEL_DIV1K:  term = `DSP_TC_DIV1K;
            default:          run  = 1'b0;
        endcase
    end

    // One tick every divider cycles [RL17]
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!run) begin
            s_next.div_cnt = 10'h000;
        end else if (s_reg.div_cnt >= term) begin
            s_next.div_cnt = 10'h000;
            s_next.tick    = 1'b1;
        end else begin
            s_next.div_cnt = s_reg.div_cnt + 10'h001;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule

//--- rtl/dsp_cmp_out.sv
`timescale 1ns/1ns
`include "dsp_regs.svh"

module dsp_cmp_out (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Timer events
    input  wire logic       run,
    input  wire logic       match,
    input  wire logic       up_slope,
    // Configuration
    input  wire logic [1:0] action,
    input  wire logic       toggle_ok,
    input  wire logic       dual,
    input  wire logic       pin_dir,
    // Pin
    output logic            pin_out,
    output logic            pin_oe
);
    import dsp_pkg::*;

    dsp_cmp_type s_reg;
    dsp_cmp_type s_next;
    logic        connected;

    // Toggle only where allowed, else disconnected [RL11] [RL12] [RL21]
    assign connected = dual && ((action == `DSP_ACT_NONINV) ||
                       (action == `DSP_ACT_INV) ||
                       (action == `DSP_ACT_TOGGLE && toggle_ok));

    // Waveform level and pin drive
    always_comb begin
        s_next = s_reg;
        if (run && match && connected) begin
            case (action)
                `DSP_ACT_TOGGLE: s_next.level = !s_reg.level; // [RL11]
                `DSP_ACT_NONINV: s_next.level = !up_slope;    // [RL4]
                `DSP_ACT_INV:    s_next.level = up_slope;     // [RL4]
                default:         s_next.level = s_reg.level;
            endcase
        end
        s_next.pin_out = connected && s_next.level;
        s_next.pin_oe  = connected && pin_dir;  // [RL5]
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_out = s_reg.pin_out;
    assign pin_oe  = s_reg.pin_oe;

endmodule

//--- rtl/dsp_pwm_top.sv
`timescale 1ns/1ns
`include "dsp_regs.svh"

// Contract
// RL1 - Modes 1,2,3,10,11 run phase correct: count up to TOP, down to zero
// RL2 - Phase correct TOP: 0xFF, 0x1FF, 0x3FF, capture-top, or compare A
// RL3 - Counter holds TOP for one tick, then counts down
// RL4 - Action 2 clears on up match, sets on down match; 3 inverts
// RL5 - Pin driven only while its direction bit selects output
// RL6 - Phase correct sets overflow flag at zero
// RL7 - Phase correct loads compares at TOP; sets A or capture flag then
// RL8 - Fixed TOP masks upper compare bits on software write
// RL9 - Software keeps new TOP at or above every compare value
// RL10 - Compare zero gives low, compare TOP gives high; inverted opposite
// RL11 - Mode 11 with action 1 toggles output A per match
// RL12 - Mode 9 with action 1 toggles output A per match
// RL13 - Modes 8,9 run frequency correct; TOP capture-top or compare A
// RL14 - Frequency correct loads compares and sets overflow at zero
// RL15 - Frequency correct sets A or capture flag at TOP
// RL16 - Register TOP from 0x0003 up to 0xFFFF; software never lower
// RL17 - Counter steps on ticks divided by 1, 8, 64, 256 or 1024
// RL18 - Compare flag set whenever count equals the compare value
// RL19 - Software changing TOP live should use frequency correct mode
// RL20 - Mode code low bits in first control, high bits in second
// RL21 - Action 1 toggles A only in modes 9, 11; otherwise disconnected
// RL22 - Matches, turns and flags act only on ticks

module dsp_pwm_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Compare output pins
    output logic             compare_output_a,
    output logic             compare_output_a_oe,
    output logic             compare_output_b,
    output logic             compare_output_b_oe
);
    import dsp_pkg::*;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // TOP for each mode [RL2] [RL13] [RL16]
    function automatic logic [15:0] top_of(input logic [3:0]  m,
                                           input logic [15:0] cap,
                                           input logic [15:0] cmp);
        case (m)
            `DSP_MODE_PC8:     top_of = `DSP_TOP_8BIT;
            `DSP_MODE_PC9:     top_of = `DSP_TOP_9BIT;
            `DSP_MODE_PC10:    top_of = `DSP_TOP_10BIT;
            `DSP_MODE_PFC_CAP: top_of = cap;
            `DSP_MODE_PC_CAP:  top_of = cap;
            `DSP_MODE_PFC_CMP: top_of = cmp;
            `DSP_MODE_PC_CMP:  top_of = cmp;
            default:           top_of = `DSP_COUNT_MAX;
        endcase
    endfunction

    // Dual-slope mode decode [RL1] [RL13]
    function automatic logic is_dual(input logic [3:0] m);
        case (m)
            `DSP_MODE_PC8, `DSP_MODE_PC9, `DSP_MODE_PC10,
            `DSP_MODE_PFC_CAP, `DSP_MODE_PFC_CMP,
            `DSP_MODE_PC_CAP, `DSP_MODE_PC_CMP: is_dual = 1'b1;
            default:                            is_dual = 1'b0;
        endcase
    endfunction

    // Mask compare write to fixed resolution [RL8]
    function automatic logic [15:0] mask_cmp(input logic [3:0]  m,
                                             input logic [15:0] v);
        case (m)
            `DSP_MODE_PC8:  mask_cmp = v & `DSP_TOP_8BIT;
            `DSP_MODE_PC9:  mask_cmp = v & `DSP_TOP_9BIT;
            `DSP_MODE_PC10: mask_cmp = v & `DSP_TOP_10BIT;
            default:        mask_cmp = v;
        endcase
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    dsp_top_type s_reg;
    dsp_top_type s_next;
    logic [3:0]  waveform_mode_code;
    logic [15:0] top;
    logic        tick;
    logic        dual;
    logic        pfc;
    logic        top_by_cap;
    logic        top_by_cmp;
    logic        run;
    logic        at_top;
    logic        at_bottom;
    logic        up_slope;
    logic        match_a;
    logic        match_b;
    logic        cnt_wr;
    logic [1:0]  output_action_code_a;
    logic [1:0]  output_action_code_b;

    // Mode code split over both control registers [RL20]
    assign waveform_mode_code = {
        s_reg.timer_control_second[`DSP_MODE_HI_MSB:`DSP_MODE_HI_LSB],
        s_reg.timer_control_first[`DSP_MODE_LO_MSB:`DSP_MODE_LO_LSB]};
    assign output_action_code_a =
        s_reg.timer_control_first[`DSP_ACT_A_MSB:`DSP_ACT_A_LSB];
    assign output_action_code_b =
        s_reg.timer_control_first[`DSP_ACT_B_MSB:`DSP_ACT_B_LSB];

    // Mode properties
    assign top  = top_of(waveform_mode_code, s_reg.capture_top_value,
                         s_reg.compare_value_a);
    assign dual = is_dual(waveform_mode_code);
    assign pfc  = (waveform_mode_code == `DSP_MODE_PFC_CAP) ||
                  (waveform_mode_code == `DSP_MODE_PFC_CMP);
    assign top_by_cap = (waveform_mode_code == `DSP_MODE_PFC_CAP) ||
                        (waveform_mode_code == `DSP_MODE_PC_CAP);
    assign top_by_cmp = (waveform_mode_code == `DSP_MODE_PFC_CMP) ||
                        (waveform_mode_code == `DSP_MODE_PC_CMP);

    // Tick-qualified events [RL22]
    assign run       = tick && dual;
    assign at_top    = s_reg.timer_count == top;
    assign at_bottom = s_reg.timer_count == `DSP_ZERO16;
    assign match_a   = s_reg.timer_count == s_reg.compare_value_a;
    assign match_b   = s_reg.timer_count == s_reg.compare_value_b;
    assign cnt_wr    = reg_wr && (reg_addr == `DSP_IDX_COUNT);

    // Bottom counts as rising, TOP as falling [RL10]
    assign up_slope  = ((s_reg.count_dir == dsp_cnt_up) && !at_top) ||
                       at_bottom;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rdata = `DSP_ZERO16;

        // Flags clear by writing one
        if (reg_wr && reg_addr == `DSP_IDX_FLAGS) begin
            s_next.flags = s_reg.flags & ~reg_wdata[5:0];
        end

        // Up/down sequence with one tick at each end [RL1] [RL3]
        if (run) begin
            case (s_reg.count_dir)
                dsp_cnt_up: begin
                    if (at_top) begin
                        s_next.count_dir   = dsp_cnt_down;
                        s_next.timer_count = s_reg.timer_count
                                             - `DSP_ONE16;
                    end else begin
                        s_next.timer_count = s_reg.timer_count
                                             + `DSP_ONE16;
                    end
                end
                dsp_cnt_down: begin
                    if (at_bottom) begin
                        s_next.count_dir   = dsp_cnt_up;
                        s_next.timer_count = s_reg.timer_count
                                             + `DSP_ONE16;
                    end else begin
                        s_next.timer_count = s_reg.timer_count
                                             - `DSP_ONE16;
                    end
                end
                default: s_next.count_dir = dsp_cnt_up;
            endcase

            // Double buffer update: TOP or BOTTOM [RL7] [RL14]
            if ((pfc && at_bottom) || (!pfc && at_top)) begin
                s_next.compare_value_a = s_reg.compare_buf_a;
                s_next.compare_value_b = s_reg.compare_buf_b;
            end

            // Flags: set wins over clear [RL6] [RL14] [RL18]
            if (at_bottom) begin
                s_next.flags[`DSP_FLAG_OVF] = 1'b1;
            end
            if (match_a || (at_top && top_by_cmp)) begin
                s_next.flags[`DSP_FLAG_CMPA] = 1'b1; // [RL7] [RL15]
            end
            if (match_b) begin
                s_next.flags[`DSP_FLAG_CMPB] = 1'b1;
            end
            if (at_top && top_by_cap) begin
                s_next.flags[`DSP_FLAG_CAP] = 1'b1;  // [RL7] [RL15]
            end
        end else if (!dual) begin
            // Outside dual-slope modes compares follow buffers at once
            s_next.compare_value_a = s_reg.compare_buf_a;
            s_next.compare_value_b = s_reg.compare_buf_b;
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `DSP_IDX_CTL_FIRST:
                    s_next.timer_control_first = reg_wdata[7:0];
                `DSP_IDX_CTL_SECOND:
                    s_next.timer_control_second = reg_wdata[4:0];
                `DSP_IDX_COUNT:
                    s_next.timer_count = reg_wdata;
                `DSP_IDX_CMP_A:
                    s_next.compare_buf_a =
                        mask_cmp(waveform_mode_code, reg_wdata); // [RL8]
                `DSP_IDX_CMP_B:
                    s_next.compare_buf_b =
                        mask_cmp(waveform_mode_code, reg_wdata); // [RL8]
                `DSP_IDX_CAP_TOP:
                    s_next.capture_top_value = reg_wdata;
                `DSP_IDX_PIN_DIR:
                    s_next.pin_direction_bit = reg_wdata[1:0];
                default: s_next.flags = s_next.flags;
            endcase
        end

        // Read data for the following cycle
        if (reg_rd) begin
            case (reg_addr)
                `DSP_IDX_CTL_FIRST:
                    s_next.rdata = {8'h00, s_reg.timer_control_first};
                `DSP_IDX_CTL_SECOND:
                    s_next.rdata = {11'h000, s_reg.timer_control_second};
                `DSP_IDX_COUNT:   s_next.rdata = s_reg.timer_count;
                `DSP_IDX_CMP_A:   s_next.rdata = s_reg.compare_buf_a;
                `DSP_IDX_CMP_B:   s_next.rdata = s_reg.compare_buf_b;
                `DSP_IDX_CAP_TOP: s_next.rdata = s_reg.capture_top_value;
                `DSP_IDX_FLAGS:   s_next.rdata = {10'h000, s_reg.flags};
                `DSP_IDX_PIN_DIR:
                    s_next.rdata = {14'h0000, s_reg.pin_direction_bit};
                default:          s_next.rdata = `DSP_ZERO16;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;

    // ----------------------------------------
    // Prescaler and compare units
    // ----------------------------------------
    dsp_presc u_presc (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_sel (s_reg.timer_control_second[`DSP_CSEL_MSB:`DSP_CSEL_LSB]),
        .tick    (tick)
    );

    // Channel A may toggle when it sets TOP [RL11] [RL12] [RL21]
    dsp_cmp_out u_cmp_a (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .run       (run),
        .match     (match_a),
        .up_slope  (up_slope),
        .action    (output_action_code_a),
        .toggle_ok (top_by_cmp),
        .dual      (dual),
        .pin_dir   (s_reg.pin_direction_bit[0]),
        .pin_out   (compare_output_a),
        .pin_oe    (compare_output_a_oe)
    );

    // Channel B never toggles [RL21]
    dsp_cmp_out u_cmp_b (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .run       (run),
        .match     (match_b),
        .up_slope  (up_slope),
        .action    (output_action_code_b),
        .toggle_ok (1'b0),
        .dual      (dual),
        .pin_dir   (s_reg.pin_direction_bit[1]),
        .pin_out   (compare_output_b),
        .pin_oe    (compare_output_b_oe)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seq_top_tick;
        run && at_top && (s_reg.count_dir == dsp_cnt_up) && !cnt_wr;
    endsequence

    sequence seq_bottom_tick;
        run && at_bottom && !cnt_wr;
    endsequence

    chk_top_reverse: assert property ( // [RL3]
        seq_top_tick |=> (s_reg.count_dir == dsp_cnt_down) &&
            (s_reg.timer_count == $past(top) - `DSP_ONE16))
        else $error("counter did not turn at TOP");

    chk_bottom_turn: assert property ( // [RL1]
        seq_bottom_tick |=> (s_reg.count_dir == dsp_cnt_up) &&
            (s_reg.timer_count == `DSP_ONE16))
        else $error("counter did not turn at zero");

    chk_fixed_top: assert property ( // [RL2]
        run && !cnt_wr && (waveform_mode_code == `DSP_MODE_PC9) &&
        (s_reg.timer_count == `DSP_TOP_9BIT) |=> !s_reg.timer_count[9])
        else $error("count passed fixed TOP");

    chk_ovf_set: assert property ( // [RL6]
        seq_bottom_tick |=> s_reg.flags[`DSP_FLAG_OVF])
        else $error("overflow flag not set at zero");

    chk_pc_load: assert property ( // [RL7]
        seq_top_tick and (!pfc) |=>
            s_reg.compare_value_a == $past(s_reg.compare_buf_a))
        else $error("compare not loaded at TOP");

    chk_pfc_load: assert property ( // [RL14]
        seq_bottom_tick and pfc |=>
            s_reg.compare_value_b == $past(s_reg.compare_buf_b))
        else $error("compare not loaded at zero");

    chk_cap_flag: assert property ( // [RL15]
        seq_top_tick and top_by_cap |=> s_reg.flags[`DSP_FLAG_CAP])
        else $error("capture flag not set at TOP");

    chk_match_flag: assert property ( // [RL18]
        run && match_b |=> s_reg.flags[`DSP_FLAG_CMPB])
        else $error("compare B flag not set on match");

    chk_mask_write: assert property ( // [RL8]
        reg_wr && (reg_addr == `DSP_IDX_CMP_A) &&
        (waveform_mode_code == `DSP_MODE_PC8) |=>
            s_reg.compare_buf_a[15:8] == 8'h00)
        else $error("compare bits above resolution kept");

    chk_idle_hold: assert property ( // [RL22]
        !tick && !cnt_wr |=> $stable(s_reg.timer_count))
        else $error("counter moved without a tick");

    chk_pin_dir: assert property ( // [RL5]
        !s_reg.pin_direction_bit[0] |=> !compare_output_a_oe)
        else $error("pin A driven while direction is input");

    chk_clear_up: assert property ( // [RL4]
        run && match_a && up_slope &&
        (output_action_code_a == `DSP_ACT_NONINV) |=> !compare_output_a)
        else $error("output A not cleared on rising match");

endmodule

//--- verif/dsp_load_model.sv
`timescale 1ns/1ns

// Port pin with a weak pull-up feeding an external load
module dsp_load_model (
    // Pin driven by the block
    input  wire logic drv_val,
    input  wire logic drv_oe,
    // Level seen at the load
    output logic      pin_level
);
    // A released pin floats up to the pull-up level
    assign pin_level = drv_oe ? drv_val : 1'b1;
endmodule

//--- verif/dsp_pwm_top_tb_top.sv
`timescale 1ns/1ns
`include "dsp_regs.svh"

module dsp_pwm_top_tb_top;
    logic        clk_sys;
    logic        rst;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        out_a;
    logic        oe_a;
    logic        out_b;
    logic        oe_b;
    logic        lvl_a;
    logic        lvl_b;
    logic        rd_d;
    logic        win;
    logic        win_d;
    logic        sel_b;
    logic [15:0] rd_q[$];
    int          hi_q[$];
    int          hi_cnt;
    int          miscompares;
    int          cmp_count;
    int          top;
    int          cv;
    int          w;
    int          e;
    int          m;
    int          dv[5] = '{1, 8, 64, 256, 1024};

    dsp_pwm_top dsp_pwm_top_i (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .compare_output_a(out_a),
        .compare_output_a_oe(oe_a), .compare_output_b(out_b),
        .compare_output_b_oe(oe_b));
    dsp_load_model load_a_i (.drv_val(out_a), .drv_oe(oe_a),
                             .pin_level(lvl_a));
    dsp_load_model load_b_i (.drv_val(out_b), .drv_oe(oe_b),
                             .pin_level(lvl_b));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check_rd(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic check_hi(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(negedge clk_sys) begin
        if (rd_d) begin
            check_rd(reg_rdata, rd_q.pop_front());
        end
    end

    // High cycles at the load are counted over each window
    always @(negedge clk_sys) begin
        // An unknown level spoils the count on purpose
        if (win) begin
            hi_cnt += ((sel_b ? lvl_b : lvl_a) === 1'b1) ? 1 :
                      ((sel_b ? lvl_b : lvl_a) === 1'b0) ? 0 : 32'h10000;
        end
        if (win_d && !win) begin
            check_hi(hi_cnt, hi_q.pop_front());
            hi_cnt = 0;
        end
        win_d = win;
    end

    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
    end

    // ----------------------------------------
    // Bus and scenario tasks
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        rd_q.push_back(exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Stop, load compares and TOP, clear count and flags
    task automatic prep(input int ca, input int cb, input int ct);
        wr(`DSP_IDX_CTL_SECOND, 16'h0000);
        wr(`DSP_IDX_CTL_FIRST, 16'h0000);
        wr(`DSP_IDX_CMP_A, 16'(ca));
        wr(`DSP_IDX_CMP_B, 16'(cb));
        wr(`DSP_IDX_CAP_TOP, 16'(ct));
        wr(`DSP_IDX_COUNT, 16'h0000);
        wr(`DSP_IDX_FLAGS, 16'h0027);
        wr(`DSP_IDX_PIN_DIR, 16'h0003);
    endtask

    task automatic cfg(input int md, input int aa, input int ab, input int cs);
        wr(`DSP_IDX_CTL_FIRST, 16'({aa[1:0], ab[1:0], 2'h0, md[1:0]}));
        wr(`DSP_IDX_CTL_SECOND, 16'({md[3:2], cs[2:0]}));
    endtask

    // Settle two windows, then count high cycles over one window
    task automatic meas(input logic b, input int n, input int exp);
        hi_q.push_back(exp);
        sel_b <= b;
        repeat (2 * n) @(posedge clk_sys);
        win <= 1'b1;
        repeat (n) @(posedge clk_sys);
        win <= 1'b0;
        @(posedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Watchdog for a hung run
    initial begin
        repeat (90000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, win, sel_b} = '0;
        rst = 1'b1;
        void'($urandom(32'h63B0));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), 16'h0000);
        end
        // Fixed TOPs mask writes; compare at TOP keeps output high
        for (m = 1; m < 4; m++) begin
            top = (256 << (m - 1)) - 1;
            prep(0, 0, 3);
            wr(`DSP_IDX_CTL_FIRST, 16'(m));
            wr(`DSP_IDX_CMP_B, 16'hFFFF);
            rd(`DSP_IDX_CMP_B, 16'(top));
            wr(`DSP_IDX_CMP_A, 16'hFFFF);
            rd(`DSP_IDX_CMP_A, 16'(top));
            cfg(m, 0, 2, 1);
            meas(1'b1, 2 * top, 2 * top);
        end
        // Flags of each register-TOP mode
        for (m = 8; m < 12; m++) begin
            prep(3, 1, 3);
            cfg(m, 2, 2, 1);
            repeat (14) @(posedge clk_sys);
            wr(`DSP_IDX_CTL_SECOND, 16'({m[3:2], 3'h0}));
            e = m[0] ? 16'h0007 : 16'h0027;
            rd(`DSP_IDX_FLAGS, 16'(e));
        end
        // Random duty on output B across every divider, A released last
        for (int i = 0; i < 8; i++) begin
            top = 3 + $urandom_range(3);
            cv = (i == 0) ? 0 : (i == 1) ? top : $urandom_range(top);
            w = 2 * top * dv[i % 5];
            e = (i % 2 == 0) ? cv * 2 * dv[i % 5] : w - cv * 2 * dv[i % 5];
            prep(cv, cv, top);
            if (i == 7) begin
                wr(`DSP_IDX_PIN_DIR, 16'h0002);
                e = w;
            end
            cfg(10, 2 + i % 2, 2 + i % 2, i % 5 + 1);
            meas(i != 7, w, e);
        end
        // Toggle on A only in modes 9 and 11, B always released
        foreach (dv[j]) begin
            if (j < 3) begin
                m = (j == 0) ? 9 : (j == 1) ? 11 : 10;
                prep(3, 1, 3);
                cfg(m, 1, 1, 1);
                meas(1'b0, 24, (m == 10) ? 24 : 12);
                meas(1'b1, 24, 24);
            end
        end
        stop_test();
    end
endmodule
